// ---- hfosc_ctrl.v ----
// Overview of operation
// - After any reset the internal oscillator is the selected system clock source.
// - Divider code 00 divides by 8, 01 by 4, 10 by 2 and 11 by 1.
// - After reset the divider is at divide by 8.
// - Writing one to the suspend bit halts the oscillator and enters suspend.
// - While suspended on the internal oscillator the core and peripheral clock is gated off until a wake event.
// - Wake events are a match on port 0, 1 or 2, or comparator 0 or 1 enabled with output low.
// - Any wake event restarts oscillator, core and peripherals regardless of interrupts.
// - After wake the core continues at the instruction after the suspending write.
// - An eight-bit fully writable calibration register sets the oscillator period.
// - At reset the calibration register loads the factory trim for 24.5 MHz; the code loads a fixed 8'h80 in its place.
// - Control bit 7 enables the oscillator when one and disables it when zero.
// - Read-only control bit 6 reads one only while the oscillator runs at its programmed frequency.
// - Control bits 4 to 2 read as zero and software writes zeros there.
// - The control register resets to enable set, ready set, suspend clear and divide by 8.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "hfosc_defs.vh"

module hfosc_ctrl (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address.
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data.
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response.
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address.
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data.
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Wake sources.
    input wire [2:0] port_match,
    input wire [1:0] comp_enable,
    input wire [1:0] comp_out,
    // Oscillator and clock control outputs.
    output reg hf_osc_run,
    output reg [7:0] hf_osc_calibration,
    output reg [1:0] hf_osc_divider_select,
    output reg [3:0] hf_osc_div_ratio,
    output reg system_clock_gate_n,
    output reg sel_internal_osc,
    output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// Registers and wiring.

reg hf_osc_enable_r;
reg suspend_r;
reg ready_r;
reg [7:0] settle_r;
reg [1:0] src_sel_r;
reg [1:0] irq_status_r;
reg [1:0] irq_mask_r;
reg [11:0] awaddr_r;
reg aw_held_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg w_held_r;
wire [4:0] wake_bit;
wire wake_any;
wire run_want;
wire wr_fire;
wire [11:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire wr_ctl;
wire wr_sus;
reg [7:0] ctl_read;
reg [31:0] rd_data;
reg rd_err;
reg wr_err;
wire wr_cal;
wire wr_src;
wire wr_mask;
wire wr_stat;
reg [7:0] settle_nxt;
reg ready_nxt;
reg [1:0] irq_status_nxt;

////////////////////////////////////////////////////////////////////////////////
// Wake sources.

// Ports 0 to 2 wake on a match; comparators 0 and 1 wake while enabled with a low output.
// The wake lines are levels taken as synchronous, so a one-cycle pulse is enough to end suspend.
genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_wake
        if (gi < 3) begin : g_port
            assign wake_bit[gi] = port_match[gi];
        end else begin : g_comp
            assign wake_bit[gi] = comp_enable[gi-3] & ~comp_out[gi-3];
        end
    end
endgenerate

// Any single source is enough to wake.
assign wake_any = |wake_bit;

// The oscillator is wanted while enabled and not suspended.
assign run_want = hf_osc_enable_r & ~suspend_r;

////////////////////////////////////////////////////////////////////////////////
// Write channel capture: address and data may arrive in either order.

// A held address or data word stands in for the live bus once its channel has been taken.
assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
// A write fires once both halves are in and no response is still waiting.
assign wr_fire = (aw_held_r | (s_axi_awvalid & s_axi_awready)) & (w_held_r | (s_axi_wvalid & s_axi_wready))
    & ~s_axi_bvalid;
assign wr_ctl = wr_fire & (wr_addr == `HFOSC_ADDR_CONTROL) & wr_strb[0];
assign wr_sus = wr_ctl & wr_data[`HFOSC_BIT_SUSPEND];

// Write strobes for the remaining registers; only byte lane 0 carries a register.
assign wr_cal = wr_fire & (wr_addr == `HFOSC_ADDR_CALIB) & wr_strb[0];
assign wr_src = wr_fire & (wr_addr == `HFOSC_ADDR_SRC_SEL) & wr_strb[0];
assign wr_mask = wr_fire & (wr_addr == `HFOSC_ADDR_IRQ_MASK) & wr_strb[0];
assign wr_stat = wr_fire & (wr_addr == `HFOSC_ADDR_IRQ_STATUS) & wr_strb[0];

// Unmapped write addresses get an error response.
always @* begin
    case (wr_addr)
        `HFOSC_ADDR_CONTROL, `HFOSC_ADDR_CALIB, `HFOSC_ADDR_IRQ_STATUS, `HFOSC_ADDR_IRQ_MASK,
        `HFOSC_ADDR_SRC_SEL: wr_err = 1'b0;
        default: wr_err = 1'b1;
    endcase
end

// Handshake tracking for the write address, write data and response.
// The readies fall while a response waits, so only one write is under way at a time.
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        awaddr_r <= 12'h000;
        wdata_r <= 32'h0000_0000;
        wstrb_r <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `HFOSC_RESP_OKAY;
    end else begin
        s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid & ~wr_fire;
        s_axi_wready <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid & ~wr_fire;
        if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `HFOSC_RESP_SLVERR : `HFOSC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Oscillator control registers.

// Control, calibration, source select and interrupt registers.
always @(posedge aclk) begin
    if (!aresetn) begin
        hf_osc_enable_r <= 1'b1;
        suspend_r <= 1'b0;
        hf_osc_divider_select <= `HFOSC_DIV_RESET;
        hf_osc_calibration <= `HFOSC_CALIB_RESET;
        src_sel_r <= 2'h0;
        irq_mask_r <= 2'h0;
        irq_status_r <= 2'h0;
    end else begin
        if (wr_ctl) begin
            hf_osc_enable_r <= wr_data[`HFOSC_BIT_ENABLE];
            hf_osc_divider_select <= wr_data[1:0];
        end
        // A wake event clears suspend; the write that sets it wins only with no wake present.
        // Software cannot clear suspend itself; only a wake ends it, and the oscillator then keeps running.
        if (wr_sus & ~wake_any) begin
            suspend_r <= 1'b1;
        end else if (suspend_r & wake_any) begin
            suspend_r <= 1'b0;
        end
        if (wr_cal) begin
            hf_osc_calibration <= wr_data[7:0];
        end
        if (wr_src) begin
            src_sel_r <= wr_data[1:0];
        end
        if (wr_mask) begin
            irq_mask_r <= wr_data[1:0];
        end
        // Sticky event bits, with the write-one clear already folded in.
        irq_status_r <= irq_status_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Frequency-ready tracking.

// Next settle count and ready flag; losing run or changing the divider code restarts the count.
// Ready is held low for the whole count so software never sees it high at a stale frequency.
always @* begin
    settle_nxt = settle_r;
    ready_nxt = ready_r;
    if (~run_want | (wr_ctl & (wr_data[1:0] != hf_osc_divider_select))) begin
        ready_nxt = 1'b0;
        settle_nxt = `HFOSC_SETTLE_CYC;
    end else if (settle_r > 8'h01) begin
        settle_nxt = settle_r - 8'h01;
    end else if (settle_r == 8'h01) begin
        settle_nxt = 8'h00;
        ready_nxt = 1'b1;
    end
end

// Oscillator run state and frequency-ready settle counter.
always @(posedge aclk) begin
    if (!aresetn) begin
        hf_osc_run <= 1'b1;
        ready_r <= 1'b1;
        settle_r <= 8'h00;
    end else begin
        hf_osc_run <= run_want;
        ready_r <= ready_nxt;
        settle_r <= settle_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupts.

// Write-one clear first, then the events, so a new event wins over a clear in the same cycle.
always @* begin
    irq_status_nxt = irq_status_r & ~({2{wr_stat}} & wr_data[1:0]);
    if (suspend_r & wake_any) begin
        irq_status_nxt[`HFOSC_IRQ_WAKE] = 1'b1;
    end
    if (ready_nxt & ~ready_r) begin
        irq_status_nxt[`HFOSC_IRQ_READY] = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Clock outputs.

// Divide ratio, clock gate, source select and interrupt outputs.
always @(posedge aclk) begin
    if (!aresetn) begin
        hf_osc_div_ratio <= 4'h8;
        system_clock_gate_n <= 1'b1;
        sel_internal_osc <= 1'b1;
        irq <= 1'b0;
    end else begin
        case (hf_osc_divider_select)
            2'h0: hf_osc_div_ratio <= 4'h8;
            2'h1: hf_osc_div_ratio <= 4'h4;
            2'h2: hf_osc_div_ratio <= 4'h2;
            default: hf_osc_div_ratio <= 4'h1;
        endcase
        // Gating only holds the core, so it resumes after the suspending write.
        // The gate is registered and opens one cycle after a wake; another clock source is never gated.
        system_clock_gate_n <= ~(suspend_r & ~wake_any & (src_sel_r == 2'h0));
        sel_internal_osc <= (src_sel_r == 2'h0);
        irq <= |(irq_status_r & irq_mask_r);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel.

// Control readback with reserved bits as zero.
always @* begin
    ctl_read = 8'h00;
    ctl_read[`HFOSC_BIT_ENABLE] = hf_osc_enable_r;
    ctl_read[`HFOSC_BIT_READY] = ready_r;
    ctl_read[`HFOSC_BIT_SUSPEND] = suspend_r;
    ctl_read[1:0] = hf_osc_divider_select;
end

// Read data multiplexer.
// The live read address is decoded; the master holds it unchanged until it is taken.
always @* begin
    rd_err = 1'b0;
    case (s_axi_araddr)
        `HFOSC_ADDR_CONTROL: rd_data = {24'h00_0000, ctl_read};
        `HFOSC_ADDR_CALIB: rd_data = {24'h00_0000, hf_osc_calibration};
        `HFOSC_ADDR_IRQ_STATUS: rd_data = {30'h0000_0000, irq_status_r};
        `HFOSC_ADDR_IRQ_MASK: rd_data = {30'h0000_0000, irq_mask_r};
        `HFOSC_ADDR_SRC_SEL: rd_data = {30'h0000_0000, src_sel_r};
        default: begin
            rd_data = 32'h0000_0000;
            rd_err = 1'b1;
        end
    endcase
end

// Read handshake: one cycle from address accept to data.
// The address ready stays low while data waits, so a second read cannot overtake the first.
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `HFOSC_RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `HFOSC_RESP_SLVERR : `HFOSC_RESP_OKAY;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // hfosc_ctrl

// ---- hfosc_ctrl_assertions.sv ----
`timescale 1ns/100ps
`include "hfosc_defs.vh"
module hfosc_chk (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Read handshakes.
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Wake sources.
    input wire [2:0] port_match,
    input wire [1:0] comp_enable,
    input wire [1:0] comp_out,
    // Clock control outputs.
    input wire hf_osc_run,
    input wire [7:0] hf_osc_calibration,
    input wire [1:0] hf_osc_divider_select,
    input wire [3:0] hf_osc_div_ratio,
    input wire system_clock_gate_n,
    input wire sel_internal_osc
);
    // Any port match or an enabled comparator driven low counts as a wake.
    wire wake = (port_match != 3'h0) || ((comp_enable & ~comp_out) != 2'h0);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Gated state, and a wake arriving right after it.
    sequence s_asleep;
        !system_clock_gate_n;
    endsequence
    sequence s_wake_seen;
        s_asleep ##1 wake;
    endsequence
    property p_ratio;
        $stable(hf_osc_divider_select) ##1 $stable(hf_osc_divider_select) |-> hf_osc_div_ratio == (4'h8 >> hf_osc_divider_select);
    endproperty
    a_ratio: assert property (p_ratio) else $error("divider ratio does not follow code");
    property p_reset;
        $rose(aresetn) |-> hf_osc_run && sel_internal_osc && hf_osc_div_ratio == 4'h8 && hf_osc_calibration == `HFOSC_CALIB_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("wrong state after reset");
    property p_gate_src;
        s_asleep |-> sel_internal_osc;
    endproperty
    a_gate_src: assert property (p_gate_src) else $error("clock gated with other source");
    property p_asleep_run;
        s_asleep ##1 s_asleep |-> !hf_osc_run;
    endproperty
    a_asleep_run: assert property (p_asleep_run) else $error("oscillator runs while gated");
    property p_wake_hold;
        wake |=> system_clock_gate_n;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("clock gated during wake");
    property p_resume;
        s_wake_seen |-> ##[1:3] hf_osc_run;
    endproperty
    a_resume: assert property (p_resume) else $error("oscillator not restarted by wake");
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_rdone;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdone: assert property (p_rdone) else $error("read answer repeated");
endmodule // hfosc_chk
bind hfosc_ctrl hfosc_chk i_hfosc_chk (.*);

// ---- hfosc_ctrl_tb.sv ----
`timescale 1ns/100ps
`include "hfosc_defs.vh"
module hfosc_ctrl_tb;
    reg aclk = 1'b0, aresetn = 1'b0, wake_on = 1'b0, done;
    reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    reg [31:0] s_axi_wdata = 32'h0000_0000, rd;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [2:0] wake_sel = 3'h0;
    reg [1:0] rsp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, hf_osc_run, system_clock_gate_n;
    wire sel_internal_osc, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp, hf_osc_divider_select, comp_enable, comp_out;
    wire [31:0] s_axi_rdata;
    wire [2:0] port_match;
    wire [7:0] hf_osc_calibration;
    wire [3:0] hf_osc_div_ratio;
    wire [15:0] core_ticks;
    reg [15:0] ticks;
    integer n_errors = 0, total_checks = 0, i, n;
    localparam [11:0] a_ctl = `HFOSC_ADDR_CONTROL;
    hfosc_ctrl i_hfosc_ctrl (.*);
    hfosc_wake_model i_hfosc_wake_model (.*);
    // Free running clock.
    initial forever #2 aclk = ~aclk;
    // Compare and count.
    task chk(input [8*10:1] name, input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task final_report;
        begin
            if (n_errors == 0 && total_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // One bus transfer; each valid drops once taken, the answer ends it.
    task bus(input wr, input [11:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
            {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
            done = 1'b0;
            for (n = 0; n < 40 && !done; n = n + 1) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bready <= 1'b0;
                    {rsp, done} = {s_axi_bresp, 1'b1};
                end
                if (s_axi_rvalid && s_axi_rready) begin
                    s_axi_rready <= 1'b0;
                    {rd, rsp, done} = {s_axi_rdata, s_axi_rresp, 1'b1};
                end
            end
            if (!done) begin
                chk("timeout", done, 1);
                final_report;
            end
        end
    endtask
    // Pulse one wake source and let the block resume.
    task wake(input [2:0] s);
        begin
            {wake_sel, wake_on} <= {s, 1'b1};
            @(posedge aclk);
            wake_on <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("ratio", hf_osc_div_ratio, 32'h8);
        chk("src", sel_internal_osc, 32'h1);
        bus(0, a_ctl, 0);
        chk("ctl_rst", rd, 32'h0000_00c0);
        bus(0, `HFOSC_ADDR_CALIB, 0);
        chk("cal_rst", rd, `HFOSC_CALIB_RESET);
        for (i = 1; i < 5; i = i + 1) begin
            bus(1, a_ctl, 32'h0000_0080 | (i % 4));
            bus(0, a_ctl, 0);
            chk("ctl_div", rd, 32'h0000_0080 | (i % 4));
            repeat (30) @(posedge aclk);
            bus(0, a_ctl, 0);
            chk("ctl_rdy", rd, 32'h0000_00c0 | (i % 4));
            chk("ratio", hf_osc_div_ratio, 32'h8 >> (i % 4));
            chk("div_out", hf_osc_divider_select, i % 4);
        end
        for (i = 0; i < 2; i = i + 1) begin
            bus(1, `HFOSC_ADDR_CALIB, 32'h0000_00a5 ^ (i * 32'h0000_00ff));
            chk("wr_okay", rsp, 0);
            bus(0, `HFOSC_ADDR_CALIB, 0);
            chk("cal", rd, 32'h0000_00a5 ^ (i * 32'h0000_00ff));
            chk("cal_out", hf_osc_calibration, 32'h0000_00a5 ^ (i * 32'h0000_00ff));
        end
        bus(1, a_ctl, 0);
        repeat (3) @(posedge aclk);
        chk("run_off", hf_osc_run, 0);
        bus(0, a_ctl, 0);
        chk("ctl_off", rd, 0);
        bus(1, a_ctl, 32'h0000_0080);
        bus(1, `HFOSC_ADDR_SRC_SEL, 0);
        for (i = 0; i < 5; i = i + 1) begin
            bus(1, a_ctl, 32'h0000_00a0);
            repeat (4) @(posedge aclk);
            ticks = core_ticks;
            repeat (4) @(posedge aclk);
            chk("gated", system_clock_gate_n, 0);
            chk("ticks", core_ticks, ticks);
            chk("run_susp", hf_osc_run, 0);
            wake(i);
            chk("woken", system_clock_gate_n, 1);
            chk("run_wake", hf_osc_run, 1);
            bus(0, a_ctl, 0);
            chk("ctl_wake", rd, 32'h0000_0080);
        end
        bus(1, a_ctl, 32'h0000_00a0);
        wake(5);
        wake(6);
        chk("cmp_high", system_clock_gate_n, 0);
        wake(3);
        chk("cmp_low", system_clock_gate_n, 1);
        chk("irq_mask", irq, 0);
        bus(1, `HFOSC_ADDR_IRQ_MASK, 1);
        repeat (2) @(posedge aclk);
        chk("irq_on", irq, 1);
        bus(1, `HFOSC_ADDR_IRQ_STATUS, 3);
        repeat (2) @(posedge aclk);
        chk("irq_clr", irq, 0);
        bus(1, `HFOSC_ADDR_SRC_SEL, 1);
        bus(1, a_ctl, 32'h0000_00a0);
        repeat (8) @(posedge aclk);
        chk("no_gate", system_clock_gate_n, 1);
        chk("src_ext", sel_internal_osc, 0);
        wake(0);
        bus(1, `HFOSC_ADDR_SRC_SEL, 0);
        bus(1, 12'h010, 32'h0000_00ff);
        chk("wresp", rsp, 2);
        bus(0, 12'h010, 0);
        chk("rresp", rsp, 2);
        final_report;
    end
endmodule // hfosc_ctrl_tb

// ---- hfosc_defs.vh ----
`ifndef HFOSC_DEFS_VH
`define HFOSC_DEFS_VH
// Register byte offsets (index times four, as printed offsets are not word aligned).
`define HFOSC_IDX_CONTROL 8'hb7
`define HFOSC_IDX_CALIB 8'hbf
`define HFOSC_ADDR_CONTROL 12'h2dc
`define HFOSC_ADDR_CALIB 12'h2fc
`define HFOSC_ADDR_IRQ_STATUS 12'h400
`define HFOSC_ADDR_IRQ_MASK 12'h404
`define HFOSC_ADDR_SRC_SEL 12'h408
// Control register fields.
`define HFOSC_BIT_ENABLE 7
`define HFOSC_BIT_READY 6
`define HFOSC_BIT_SUSPEND 5
`define HFOSC_DIV_LSB 0
`define HFOSC_CONTROL_RESET 8'hc0
`define HFOSC_DIV_RESET 2'h0
// Arbitrary calibration default standing in for the factory trim.
`define HFOSC_CALIB_RESET 8'h80
// Interrupt status bits.
`define HFOSC_IRQ_WAKE 0
`define HFOSC_IRQ_READY 1
// Ready settle time after run starts or the divider changes: 100 ns at the 4 ns clock, in cycles.
`define HFOSC_SETTLE_CYC 8'h19
// AXI responses.
`define HFOSC_RESP_OKAY 2'h0
`define HFOSC_RESP_SLVERR 2'h2
`endif

// ---- hfosc_wake_model.sv ----
`timescale 1ns/100ps
module hfosc_wake_model (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Wake request: source 0..2 ports, 3..4 comparators.
    input wire [2:0] wake_sel,
    input wire wake_on,
    input wire system_clock_gate_n,
    // Wake lines and core clock ticks.
    output reg [2:0] port_match = 3'h0,
    output reg [1:0] comp_enable = 2'h0,
    output reg [1:0] comp_out = 2'h0,
    output reg [15:0] core_ticks = 16'h0000
);
    // Codes 3 and 4 enable a comparator with a low output; codes 5 and 6 enable one with a high output.
    always @(posedge aclk) begin
        port_match <= (wake_on && wake_sel < 3'h3) ? 3'h1 << wake_sel : 3'h0;
        comp_enable <= (wake_on && wake_sel > 3'h2) ? (wake_sel[0] ? 2'h1 : 2'h2) : 2'h0;
        comp_out <= (wake_on && wake_sel > 3'h4) ? (wake_sel[0] ? 2'h1 : 2'h2) : 2'h0;
        core_ticks <= aresetn ? core_ticks + {15'h0000, system_clock_gate_n} : 16'h0000;
    end
endmodule // hfosc_wake_model
